/* common/mcfs_pkg.sv */
`default_nettype none
package mcfs_pkg;

  // ****************************************
  // sequencing steps
  // ****************************************
  localparam int PC_STEP   = 1;  // normal advance of the program counter
  localparam int SKIP_STEP = 2;  // advance past a discarded instruction
  localparam int SP_STEP   = 2;  // one stack entry takes two bytes

  // ****************************************
  // reset values and address limits
  // ****************************************
  localparam logic [7:0] SP_RESET   = 8'h00;  // stack pointer after reset
  localparam logic [7:0] BIT_RAM_HI = 8'h3F;  // highest bit-addressable ram byte

  // ****************************************
  // flag update masks, bit 0 zero, 1 carry, 2 aux carry, 3 overflow
  // ****************************************
  localparam int         FLAG_W  = 4;
  localparam logic [3:0] FM_NONE = 4'h0;
  localparam logic [3:0] FM_Z    = 4'h1;
  localparam logic [3:0] FM_C    = 4'h2;
  localparam logic [3:0] FM_ALL  = 4'hF;

  // ****************************************
  // sequencer states, one-hot
  // ****************************************
  typedef enum logic [4:0] {
    ST_RUN    = 5'h01,  // ready for the next instruction
    ST_SECOND = 5'h02,  // second cycle of a two-cycle instruction
    ST_SKIP   = 5'h04,  // discard cycle after a taken skip
    ST_HALT   = 5'h08,  // whole system halted, oscillators off
    ST_IDLE   = 5'h10   // cpu clock gated, oscillators running
  } mcfs_state_t;

  // ****************************************
  // decoded instruction classes
  // ****************************************
  typedef enum logic [4:0] {
    OP_NOFLAG      = 5'h00,  // moves and others touching no flag
    OP_ARITH       = 5'h01,  // add, sub, carry forms, inc, dec
    OP_LOGIC       = 5'h02,  // and, or, xor, not, neg, loads from ram or io
    OP_SHIFT       = 5'h03,  // shifts and io carry swap
    OP_FLAGLOAD    = 5'h04,  // flag restore
    OP_CALL        = 5'h05,
    OP_GOTO        = 5'h06,
    OP_RET         = 5'h07,
    OP_RETI        = 5'h08,
    OP_RETIMM      = 5'h09,
    OP_PCADD       = 5'h0A,
    OP_IDXM        = 5'h0B,
    OP_CMPSKIP     = 5'h0C,
    OP_INCDECSKIP  = 5'h0D,
    OP_BITSKIP_IO  = 5'h0E,
    OP_BITSKIP_RAM = 5'h0F,
    OP_BITSET_RAM  = 5'h10,  // single bit set or clear on ram
    OP_ENGINT      = 5'h11,
    OP_DISGINT     = 5'h12,
    OP_STOPSYS     = 5'h13,
    OP_STOPEXE     = 5'h14,
    OP_RESET       = 5'h15,
    OP_WDRESET     = 5'h16,
    OP_NOP         = 5'h17
  } mcfs_op_t;

endpackage : mcfs_pkg
`default_nettype wire

/* design/mcfs_flag_mask.sv */
`timescale 1ns/1ps
`default_nettype none
module mcfs_flag_mask
  import mcfs_pkg::*;
(
  input  wire mcfs_op_t   op,    // decoded instruction class
  output logic [FLAG_W-1:0] mask // flags this class updates
);

  // ****************************************
  // class to flag mask
  // ****************************************
  always_comb begin
    case (op)
      OP_ARITH, OP_CMPSKIP, OP_INCDECSKIP: mask = FM_ALL;
      OP_LOGIC:                            mask = FM_Z;
      OP_SHIFT:                            mask = FM_C;
      OP_FLAGLOAD:                         mask = FM_ALL;
      default:                             mask = FM_NONE;
    endcase
  end

endmodule : mcfs_flag_mask
`default_nettype wire

/* design/mcfs_bit_guard.sv */
`timescale 1ns/1ps
`default_nettype none
module mcfs_bit_guard
  import mcfs_pkg::*;
(
  input  wire mcfs_op_t   op,         // decoded instruction class
  input  wire logic [7:0] bit_addr,   // ram byte of a bit operation
  output logic            is_ram_bit, // class is a ram bit operation
  output logic            bit_ok      // ram bit operation allowed here
);

  // ****************************************
  // range check, lower bound is address zero
  // ****************************************
  assign is_ram_bit = (op == OP_BITSKIP_RAM) || (op == OP_BITSET_RAM);
  assign bit_ok     = !is_ram_bit || (bit_addr <= BIT_RAM_HI);

endmodule : mcfs_bit_guard
`default_nettype wire

/* design/mcfs_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module mcfs_sequencer
  import mcfs_pkg::*;
#(
  parameter int              PC_W    = 12,      // program address width
  parameter int              SP_W    = 8,       // data ram address width
  parameter logic [PC_W-1:0] INT_VEC = 'h010    // interrupt service entry
) (
  input  wire logic              core_clk,       // system clock
  input  wire logic              rst,            // synchronous reset
  input  wire logic              instr_valid,    // decoded instruction present
  output logic                   instr_ready,    // instruction can be taken this cycle
  input  wire mcfs_op_t          instr_op,       // instruction class
  input  wire logic [PC_W-1:0]   instr_target,   // jump or call target
  input  wire logic [7:0]        instr_imm,      // immediate operand
  input  wire logic [7:0]        acc_in,         // current accumulator
  input  wire logic              skip_cond,      // skip condition from alu
  input  wire logic [7:0]        bit_addr,       // ram byte of bit operation
  input  wire logic              irq_req,        // pending interrupt request
  input  wire logic              wake,           // wake from either halt
  input  wire logic [PC_W-1:0]   mem_rdata,      // stack word, cycle after read
  output logic                   mem_we,         // stack write strobe
  output logic                   mem_re,         // stack read strobe
  output logic [SP_W-1:0]        mem_addr,       // stack address
  output logic [PC_W-1:0]        mem_wdata,      // stack write word
  output logic                   irq_ack,        // interrupt taken
  output logic [PC_W-1:0]        program_counter,// current program counter
  output logic [SP_W-1:0]        stack_pointer,  // current stack pointer
  output logic                   gie,            // global interrupt enable
  output logic                   acc_load,       // load accumulator pulse
  output logic [7:0]             acc_value,      // value to load
  output logic [FLAG_W-1:0]      flag_we,        // flag update enables
  output logic                   discard_next,   // next instruction dropped
  output logic                   bit_ram_en,     // ram bit access granted
  output logic                   bit_fault,      // ram bit access refused
  output logic                   sys_halt,       // stop all clocks
  output logic                   cpu_halt,       // gate cpu clock only
  output logic                   chip_reset_req, // whole chip reset pulse
  output logic                   wdt_clear       // watchdog restart pulse
);

  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    mcfs_state_t       state;
    logic [PC_W-1:0]   pc;
    logic [SP_W-1:0]   sp;
    logic              gie;
    logic              ret_pend;
    logic              reti_pend;
    logic [FLAG_W-1:0] flag_we;
    logic              acc_load;
    logic [7:0]        acc_value;
    logic              discard;
    logic              chip_reset;
    logic              wdt_clear;
    logic              bit_fault;
  } mcfs_regs_t;

  localparam mcfs_regs_t S_RESET = '{
    state: ST_RUN, pc: '0, sp: SP_W'(SP_RESET), gie: 1'b0, ret_pend: 1'b0,
    reti_pend: 1'b0, flag_we: FM_NONE, acc_load: 1'b0, acc_value: 8'h00,
    discard: 1'b0, chip_reset: 1'b0, wdt_clear: 1'b0, bit_fault: 1'b0};

  mcfs_regs_t          s_reg;
  mcfs_regs_t          s_next;
  logic [FLAG_W-1:0]   op_mask;
  logic                is_ram_bit;
  logic                bit_ok;
  logic                accept;
  logic                irq_take;
  logic                is_ret;

  // ****************************************
  // helpers
  // ****************************************
  mcfs_flag_mask u_flag_mask (
    .op   (instr_op),
    .mask (op_mask)
  );

  mcfs_bit_guard u_bit_guard (
    .op         (instr_op),
    .bit_addr   (bit_addr),
    .is_ram_bit (is_ram_bit),
    .bit_ok     (bit_ok)
  );

  // ****************************************
  // handshake and stack port
  // ****************************************
  // interrupt wins over a new instruction at a boundary
  assign irq_take    = (s_reg.state == ST_RUN) && irq_req && s_reg.gie;
  assign instr_ready = (s_reg.state == ST_RUN) && !irq_take;
  assign accept      = instr_valid && instr_ready;
  assign irq_ack     = irq_take;
  assign is_ret      = (instr_op == OP_RET) || (instr_op == OP_RETI) ||
                       (instr_op == OP_RETIMM);
  assign mem_we      = irq_take || (accept && (instr_op == OP_CALL));
  assign mem_re      = accept && is_ret;
  assign mem_addr    = mem_re ? (s_reg.sp - SP_W'(SP_STEP)) : s_reg.sp;
  assign mem_wdata   = irq_take ? s_reg.pc : (s_reg.pc + PC_W'(PC_STEP));
  assign bit_ram_en  = accept && is_ram_bit && bit_ok;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next            = s_reg;
    s_next.flag_we    = FM_NONE;
    s_next.acc_load   = 1'b0;
    s_next.discard    = 1'b0;
    s_next.chip_reset = 1'b0;
    s_next.wdt_clear  = 1'b0;
    s_next.bit_fault  = 1'b0;
    case (s_reg.state)
      ST_RUN: begin
        if (irq_take) begin
          s_next.pc    = INT_VEC;
          s_next.sp    = s_reg.sp + SP_W'(SP_STEP);
          s_next.gie   = 1'b0;
          s_next.state = ST_SECOND;
        end else if (instr_valid) begin
          s_next.flag_we = op_mask;
          s_next.pc      = s_reg.pc + PC_W'(PC_STEP);
          case (instr_op)
            OP_CALL: begin
              s_next.pc    = instr_target;
              s_next.sp    = s_reg.sp + SP_W'(SP_STEP);
              s_next.state = ST_SECOND;
            end
            OP_GOTO: begin
              s_next.pc    = instr_target;
              s_next.state = ST_SECOND;
            end
            OP_RET, OP_RETI, OP_RETIMM: begin
              s_next.sp        = s_reg.sp - SP_W'(SP_STEP);
              s_next.ret_pend  = 1'b1;
              s_next.reti_pend = (instr_op == OP_RETI);
              s_next.state     = ST_SECOND;
              if (instr_op == OP_RETIMM) begin
                s_next.acc_load  = 1'b1;
                s_next.acc_value = instr_imm;
              end
            end
            OP_PCADD: begin
              s_next.pc    = s_reg.pc + PC_W'(acc_in);
              s_next.state = ST_SECOND;
            end
            OP_IDXM: begin
              s_next.state = ST_SECOND;
            end
            OP_CMPSKIP, OP_INCDECSKIP, OP_BITSKIP_IO, OP_BITSKIP_RAM: begin
              if (!bit_ok) begin
                s_next.bit_fault = 1'b1;
              end else if (skip_cond) begin
                s_next.pc      = s_reg.pc + PC_W'(SKIP_STEP);
                s_next.discard = 1'b1;
                s_next.state   = ST_SKIP;
              end
            end
            OP_BITSET_RAM: begin
              s_next.bit_fault = !bit_ok;
            end
            OP_ENGINT:  s_next.gie = 1'b1;
            OP_DISGINT: s_next.gie = 1'b0;
            OP_STOPSYS: s_next.state = ST_HALT;
            OP_STOPEXE: s_next.state = ST_IDLE;
            OP_RESET: begin
              s_next            = S_RESET;
              s_next.chip_reset = 1'b1;
            end
            OP_WDRESET: s_next.wdt_clear = 1'b1;
            default: ;
          endcase
        end
      end
      ST_SECOND: begin
        if (s_reg.ret_pend) begin
          s_next.pc = mem_rdata;
        end
        if (s_reg.reti_pend) begin
          s_next.gie = 1'b1;
        end
        s_next.ret_pend  = 1'b0;
        s_next.reti_pend = 1'b0;
        s_next.state     = ST_RUN;
      end
      ST_SKIP: begin
        s_next.state = ST_RUN;
      end
      ST_HALT, ST_IDLE: begin
        if (wake) begin
          s_next.state = ST_RUN;
        end
      end
      default: s_next = S_RESET;
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg <= S_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  assign program_counter = s_reg.pc;
  assign stack_pointer   = s_reg.sp;
  assign gie             = s_reg.gie;
  assign acc_load        = s_reg.acc_load;
  assign acc_value       = s_reg.acc_value;
  assign flag_we         = s_reg.flag_we;
  assign discard_next    = s_reg.discard;
  assign bit_fault       = s_reg.bit_fault;
  assign sys_halt        = (s_reg.state == ST_HALT);
  assign cpu_halt        = (s_reg.state == ST_IDLE);
  assign chip_reset_req  = s_reg.chip_reset;
  assign wdt_clear       = s_reg.wdt_clear;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_call_push: assert property (
    (accept && instr_op == OP_CALL) |-> (mem_we && mem_addr == stack_pointer &&
      mem_wdata == program_counter + PC_W'(PC_STEP)) ##1
      (program_counter == $past(instr_target) &&
       stack_pointer == SP_W'($past(stack_pointer) + SP_W'(SP_STEP))))
    else $error("call did not push and jump");

  chk_goto_target: assert property (
    (accept && instr_op == OP_GOTO) |=> program_counter == $past(instr_target))
    else $error("jump target not loaded");

  chk_ret_value: assert property (
    (accept && instr_op == OP_RETIMM) |=> (acc_load && acc_value == $past(instr_imm)))
    else $error("return value not loaded");

  chk_ret_pop: assert property (
    (accept && is_ret) |-> (mem_re && mem_addr == SP_W'(stack_pointer - SP_W'(SP_STEP)))
      ##1 (stack_pointer == $past(mem_addr) && !instr_ready)
      ##1 program_counter == $past(mem_rdata))
    else $error("return did not pop stack");

  chk_reti_gie: assert property (
    (accept && instr_op == OP_RETI) |=> ##1 gie)
    else $error("interrupt return left enable clear");

  chk_irq_entry: assert property (
    irq_ack |-> (mem_we && !instr_ready) ##1 (!gie && program_counter == INT_VEC))
    else $error("interrupt entry wrong");

  chk_pcadd_sum: assert property (
    (accept && instr_op == OP_PCADD) |=>
      program_counter == PC_W'($past(program_counter) + PC_W'($past(acc_in))))
    else $error("computed jump wrong");

  chk_gie_set: assert property (
    (accept && instr_op == OP_ENGINT) |=> gie)
    else $error("enable instruction ignored");

  chk_gie_clear: assert property (
    (accept && instr_op == OP_DISGINT) |=> !gie)
    else $error("disable instruction ignored");

  chk_halt_modes: assert property (
    (accept && instr_op == OP_STOPSYS) |=> (sys_halt && !cpu_halt && !instr_ready))
    else $error("full halt not entered");

  chk_cpu_halt: assert property (
    (accept && instr_op == OP_STOPEXE) |=> (cpu_halt && !sys_halt))
    else $error("cpu halt not entered");

  chk_soft_reset: assert property (
    (accept && instr_op == OP_RESET) |=>
      (chip_reset_req && program_counter == '0 && !gie) ##1 !chip_reset_req)
    else $error("software reset wrong");

  chk_wdt_pulse: assert property (
    (accept && instr_op == OP_WDRESET) |=> wdt_clear ##1 !wdt_clear)
    else $error("watchdog restart pulse wrong");

  chk_two_cycle: assert property (
    (accept && (instr_op inside {OP_CALL, OP_GOTO, OP_PCADD, OP_IDXM} || is_ret))
      |=> !instr_ready ##1 (s_reg.state == ST_RUN))
    else $error("two cycle timing wrong");

  chk_skip_time: assert property (
    (accept && instr_op inside {OP_CMPSKIP, OP_INCDECSKIP, OP_BITSKIP_IO} && skip_cond)
      |=> (discard_next && !instr_ready &&
           program_counter == PC_W'($past(program_counter) + PC_W'(SKIP_STEP)))
      ##1 (s_reg.state == ST_RUN && !discard_next))
    else $error("skip timing wrong");

  chk_no_skip: assert property (
    (accept && instr_op == OP_CMPSKIP && !skip_cond) |=> (s_reg.state == ST_RUN))
    else $error("untaken skip took two cycles");

  chk_flag_mask: assert property (
    accept |=> (flag_we == $past(op_mask) || $past(instr_op) == OP_RESET))
    else $error("flag enables wrong");

  chk_ctrl_flags: assert property (
    (accept && instr_op inside {OP_CALL, OP_GOTO, OP_RET, OP_RETI, OP_PCADD, OP_NOP})
      |=> flag_we == FM_NONE)
    else $error("control instruction touched flags");

  chk_bit_range: assert property (
    (accept && is_ram_bit) |-> (bit_ram_en == (bit_addr <= BIT_RAM_HI)) ##1
      (bit_fault == ($past(bit_addr) > BIT_RAM_HI)))
    else $error("ram bit range check wrong");

  cov_call: cover property (accept && instr_op == OP_CALL ##2 accept && is_ret);
  cov_irq:  cover property (irq_ack ##2 accept && instr_op == OP_RETI);
  cov_skip: cover property (accept && instr_op == OP_INCDECSKIP && skip_cond);
  cov_halt: cover property (sys_halt ##1 wake);
  cov_bitf: cover property (bit_fault);

endmodule : mcfs_sequencer
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mcfs_pkg::*;
  // ****************************************
  // design hookup
  // ****************************************
  logic        core_clk, rst, instr_valid, skip_cond, irq_req, wake;
  logic        instr_ready, mem_we, mem_re, irq_ack, gie, acc_load;
  logic        discard_next, bit_ram_en, bit_fault, sys_halt, cpu_halt;
  logic        chip_reset_req, wdt_clear, w0, e0, r0;
  mcfs_op_t    instr_op;
  logic [11:0] instr_target, mem_rdata, mem_wdata, program_counter, p0, d0;
  logic [11:0] stk [256];
  logic [7:0]  instr_imm, acc_in, bit_addr, mem_addr, stack_pointer, acc_value, s0, a0;
  logic [3:0]  flag_we;
  int          n_fail, check_count;
  mcfs_op_t    sk_ops [4] = '{OP_CMPSKIP, OP_INCDECSKIP, OP_BITSKIP_IO, OP_BITSKIP_RAM};
  mcfs_op_t    fl_ops [7] = '{OP_ARITH, OP_LOGIC, OP_SHIFT, OP_FLAGLOAD, OP_NOFLAG, OP_NOP,
                              OP_BITSET_RAM};

  mcfs_sequencer i_dut (
    .core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_op(instr_op), .instr_target(instr_target), .instr_imm(instr_imm),
    .acc_in(acc_in), .skip_cond(skip_cond), .bit_addr(bit_addr), .irq_req(irq_req),
    .wake(wake), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_re(mem_re),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .irq_ack(irq_ack),
    .program_counter(program_counter), .stack_pointer(stack_pointer), .gie(gie),
    .acc_load(acc_load), .acc_value(acc_value), .flag_we(flag_we),
    .discard_next(discard_next), .bit_ram_en(bit_ram_en), .bit_fault(bit_fault),
    .sys_halt(sys_halt), .cpu_halt(cpu_halt), .chip_reset_req(chip_reset_req),
    .wdt_clear(wdt_clear)
  );

  // 125 MHz system clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // stack ram; read word valid only in the cycle after the read strobe
  always @(posedge core_clk) begin
    if (mem_we === 1'b1)
      stk[mem_addr] <= mem_wdata;
    if (rst)
      mem_rdata <= '0;
    else
      mem_rdata <= (mem_re === 1'b1) ? stk[mem_addr] : ~mem_rdata;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  function automatic logic [3:0] fmask(input mcfs_op_t op);
    case (op)
      OP_ARITH, OP_FLAGLOAD, OP_CMPSKIP, OP_INCDECSKIP: return FM_ALL;
      OP_LOGIC: return FM_Z;
      OP_SHIFT: return FM_C;
      default: return FM_NONE;
    endcase
  endfunction : fmask

  // offer one instruction, capture cycle 0, return in cycle 1
  task automatic do_op(input mcfs_op_t op, input logic [11:0] t, input logic [7:0] v,
                       input logic sk, input logic [7:0] ba);
    int n;
    @(posedge core_clk);
    instr_valid  <= 1'b1;
    instr_op     <= op;
    instr_target <= t;
    instr_imm    <= v;
    acc_in       <= v;
    skip_cond    <= sk;
    bit_addr     <= ba;
    #1;
    n = 0;
    while (instr_ready !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("rdy_wait", n < 40, 1'b1);
    {p0, s0, w0, r0, e0, d0, a0} = {program_counter, stack_pointer, mem_we, mem_re,
                                    bit_ram_en, mem_wdata, mem_addr};
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
    chk("flag_we", flag_we, fmask(op));
  endtask : do_op

  // hold an interrupt request while it must stay blocked
  task automatic irq_blocked;
    repeat (4) begin
      @(posedge core_clk);
      irq_req <= 1'b1;
      #1;
      chk("irq_blk", irq_ack, 1'b0);
    end
    @(posedge core_clk);
    irq_req <= 1'b0;
  endtask : irq_blocked

  // stay halted until wake, then resume
  task automatic wake_up;
    int n;
    repeat (3) @(posedge core_clk);
    #1;
    chk("halt_rdy", instr_ready, 1'b0);
    @(posedge core_clk);
    wake <= 1'b1;
    @(posedge core_clk);
    wake <= 1'b0;
    #1;
    n = 0;
    while (instr_ready !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("halt_off", {sys_halt, cpu_halt, instr_ready}, 3'b001);
  endtask : wake_up

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    int n;
    {rst, instr_valid, skip_cond, irq_req, wake} = 5'b10000;
    {instr_target, instr_imm, acc_in, bit_addr} = '0;
    instr_op = OP_NOP;
    {n_fail, check_count} = '0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("rst_st", {instr_ready, gie, stack_pointer, program_counter}, 22'h200000);
    do_op(OP_GOTO, 12'h7FE, 8'h00, 1'b0, 8'h00);
    chk("goto", {instr_ready, program_counter}, 13'h07FE);
    do_op(OP_CALL, 12'hABC, 8'h00, 1'b0, 8'h00);
    chk("call_st", {w0, a0, d0}, {1'b1, s0, 12'h7FF});
    chk("call_pc", {instr_ready, program_counter}, 13'h0ABC);
    chk("call_sp", stack_pointer, 8'(s0 + 8'h02));
    do_op(OP_RETIMM, 12'h000, 8'h55, 1'b0, 8'h00);
    chk("ret_rd", {r0, a0, stack_pointer}, {1'b1, 8'(s0 - 8'h02), 8'(s0 - 8'h02)});
    chk("ret_acc", {acc_load, acc_value}, 9'h155);
    @(posedge core_clk);
    #1;
    chk("ret_pc", program_counter, 12'h7FF);
    do_op(OP_ENGINT, 12'h000, 8'h00, 1'b0, 8'h00);
    chk("gie_on", gie, 1'b1);
    @(posedge core_clk);
    irq_req <= 1'b1;
    #1;
    n = 0;
    while (irq_ack !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("irq_st", {irq_ack, mem_we, mem_wdata}, 14'h3800);
    @(posedge core_clk);
    #1;
    chk("irq_pc", {gie, program_counter}, 13'h0010);
    irq_blocked;
    do_op(OP_RETI, 12'h000, 8'h00, 1'b0, 8'h00);
    @(posedge core_clk);
    #1;
    chk("reti", {gie, program_counter}, 13'h1800);
    do_op(OP_DISGINT, 12'h000, 8'h00, 1'b0, 8'h00);
    chk("gie_off", gie, 1'b0);
    irq_blocked;
    do_op(OP_PCADD, 12'h000, 8'hF3, 1'b0, 8'h00);
    chk("pcadd", {instr_ready, program_counter}, {1'b0, 12'(p0 + 12'h0F3)});
    do_op(OP_IDXM, 12'h000, 8'h00, 1'b0, 8'h00);
    chk("idxm_rdy", instr_ready, 1'b0);
    foreach (sk_ops[i]) begin
      for (int k = 0; k < 2; k++) begin
        do_op(sk_ops[i], 12'h000, 8'h00, k[0], BIT_RAM_HI);
        chk("skip_pc", program_counter, 12'(p0 + 12'(k + 1)));
        chk("skip_disc", {discard_next, instr_ready}, {k[0], ~k[0]});
      end
    end
    foreach (fl_ops[i]) begin
      do_op(fl_ops[i], 12'h000, 8'h00, 1'b0, 8'h10);
      chk("one_cyc", {instr_ready, program_counter}, {1'b1, 12'(p0 + 12'h001)});
    end
    do_op(OP_WDRESET, 12'h000, 8'h00, 1'b0, 8'h00);
    chk("wdt", wdt_clear, 1'b1);
    for (int k = 0; k < 2; k++) begin
      do_op(OP_BITSET_RAM, 12'h000, 8'h00, 1'b0, 8'(BIT_RAM_HI + k));
      chk("bit_gate", {e0, bit_fault}, {~k[0], k[0]});
    end
    do_op(OP_BITSKIP_RAM, 12'h000, 8'h00, 1'b1, 8'h40);
    chk("bit_noskip", {discard_next, program_counter}, {1'b0, 12'(p0 + 12'h001)});
    do_op(OP_STOPEXE, 12'h000, 8'h00, 1'b0, 8'h00);
    chk("stopexe", {sys_halt, cpu_halt}, 2'b01);
    wake_up;
    do_op(OP_STOPSYS, 12'h000, 8'h00, 1'b0, 8'h00);
    chk("stopsys", {sys_halt, cpu_halt}, 2'b10);
    wake_up;
    do_op(OP_ENGINT, 12'h000, 8'h00, 1'b0, 8'h00);
    do_op(OP_CALL, 12'h100, 8'h00, 1'b0, 8'h00);
    n = int'(d0);
    do_op(OP_RET, 12'h000, 8'h00, 1'b0, 8'h00);
    chk("ret_noacc", acc_load, 1'b0);
    @(posedge core_clk);
    #1;
    chk("ret_plain", program_counter, n[11:0]);
    do_op(OP_CALL, 12'h100, 8'h00, 1'b0, 8'h00);
    do_op(OP_RESET, 12'h000, 8'h00, 1'b0, 8'h00);
    chk("sw_rst", {chip_reset_req, gie, stack_pointer, program_counter}, 22'h200000);
    tally_and_finish;
  end

  // hang guard
  initial begin
    #20000;
    n_fail++;
    tally_and_finish;
  end
endmodule : tb
`default_nettype wire
